// File: bench/test_wwan_sideband.sv
`timescale 1ns/10ps
module test_wwan_sideband;
  import sideband_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic radio_kill_n, body_proximity_n, tx_burst, burst_blank, radio_enable, flight_mode;
  logic [7:0] tx_power_max, rx_byte, n_bits, nom, thr, band;
  logic refclk_enable, sclk_out, sclk_oe, sdat_out, sdat_oe, muted, sw;
  logic [2:0] tuner_par, config_strap, par;
  int n_fail, n_compared;

  wwan_sideband wwan_sideband_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .radio_kill_n(radio_kill_n),
    .body_proximity_n(body_proximity_n), .tx_burst(tx_burst), .burst_blank(burst_blank),
    .radio_enable(radio_enable), .flight_mode(flight_mode), .tx_power_max(tx_power_max),
    .refclk_enable(refclk_enable), .tuner_par(tuner_par), .tuner_serial_clk_out(sclk_out),
    .tuner_serial_clk_oe(sclk_oe), .tuner_serial_dat_out(sdat_out),
    .tuner_serial_dat_oe(sdat_oe), .config_strap(config_strap));

  tuner_model tuner_model_i (.hclk(hclk), .hresetn(hresetn), .clk_out(sclk_out),
    .clk_oe(sclk_oe), .dat_out(sdat_out), .dat_oe(sdat_oe), .burst_blank(burst_blank),
    .rx_byte(rx_byte), .n_bits(n_bits), .positioning_muted(muted));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic finish_test;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_fail++;
        finish_test;
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : ~d;
    wait_ready;
    rd = hrdata;
  endtask

  task automatic settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask

  function automatic logic blank_exp(input logic tx, input logic kill_n, input logic [7:0] b);
    return tx & kill_n & (b == 8'h27);
  endfunction

  initial begin
    {hsel, hwrite, tx_burst} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    {radio_kill_n, body_proximity_n} = 2'h3;
    hresetn = 1'b0;
    n_fail = 0;
    n_compared = 0;
    void'($urandom(31));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    // Reset state
    check("refclk", 32'(refclk_enable), 32'h0);
    check("strap", 32'(config_strap), 32'h0);
    check("blank", 32'(burst_blank), 32'h0);
    check("power", 32'(tx_power_max), 32'h17);
    check("okay", 32'({hreadyout, hresp}), 32'h2);
    bus(CTRL_OFF, 1'b0, 32'h0);
    check("ctrl", rd, 32'h1);
    bus(POWER_OFF, 1'b0, 32'h0);
    check("power reg", rd, 32'h1017);
    bus(STATUS_OFF, 1'b0, 32'h0);
    check("straps", 32'(rd[11:8]), 32'h8);
    bus(8'h14, 1'b1, 32'hFFFFFFFF);
    bus(8'h14, 1'b0, 32'h0);
    check("unmapped", rd, 32'h0);
    // Radio kill, software switch, reference clock
    for (int i = 0; i < 10; i++) begin
      sw = (i < 2) ? 1'b1 : 1'($urandom);
      radio_kill_n <= (i < 2) ? 1'(i) : 1'($urandom);
      bus(CTRL_OFF, 1'b1, {29'h0, 1'b0, 1'(i), sw});
      settle;
      check("radio", 32'(radio_enable), 32'(radio_kill_n & sw));
      check("flight", 32'(flight_mode), 32'(!(radio_kill_n & sw)));
      check("refclk", 32'(refclk_enable), 32'(i % 2));
    end
    // Proximity power cap
    for (int i = 0; i < 10; i++) begin
      nom = 8'($urandom);
      thr = 8'($urandom);
      body_proximity_n <= (i < 2) ? 1'(i) : 1'($urandom);
      bus(POWER_OFF, 1'b1, {16'h0, thr, nom});
      settle;
      check("cap", 32'(tx_power_max), 32'(body_proximity_n ? nom : thr));
      bus(STATUS_OFF, 1'b0, 32'h0);
      check("cap stat", 32'(rd[23:16]), 32'(body_proximity_n ? nom : thr));
    end
    // Blanking follows bursts only in the blanking band
    bus(CTRL_OFF, 1'b1, 32'h1);
    for (int i = 0; i < 16; i++) begin
      band = (i % 2 == 0) ? 8'h27 : 8'($urandom);
      radio_kill_n <= (i < 4) ? 1'b1 : 1'($urandom);
      tx_burst <= (i < 4) ? 1'(i < 2) : 1'($urandom);
      bus(BAND_OFF, 1'b1, {24'h0, band});
      settle;
      check("blank", 32'(burst_blank), 32'(blank_exp(tx_burst, radio_kill_n, band)));
      check("muted", 32'(muted), 32'(blank_exp(tx_burst, radio_kill_n, band)));
    end
    tx_burst <= 1'b0;
    radio_kill_n <= 1'b1;
    // Parallel tuner
    for (int i = 0; i < 6; i++) begin
      par = 3'($urandom);
      bus(TUNER_OFF, 1'b1, {29'h0, par});
      settle;
      check("par", 32'(tuner_par), 32'(par));
      check("oe", 32'({sclk_oe, sdat_oe}), 32'h0);
    end
    // Serial tuner, two frames; a byte written while busy is ignored
    bus(CTRL_OFF, 1'b1, 32'h5);
    for (int f = 1; f <= 2; f++) begin
      nom = 8'($urandom) | 8'h81;
      bus(TUNER_OFF, 1'b1, {16'h0, nom, 8'h00});
      bus(STATUS_OFF, 1'b0, 32'h0);
      check("busy on", 32'(rd[4]), 32'h1);
      bus(TUNER_OFF, 1'b1, {16'h0, ~nom, 8'h00});
      for (int k = 0; n_bits !== 8'(8 * f); k++) begin
        if (k > 400) begin
          n_fail++;
          finish_test;
        end
        @(posedge hclk);
        check("od out", 32'({sclk_out, sdat_out}), 32'h0);
      end
      settle;
      repeat (20) @(posedge hclk);
      check("serial byte", 32'(rx_byte), 32'(nom));
      check("serial bits", 32'(n_bits), 32'(8 * f));
    end
    check("par off", 32'(tuner_par), 32'h0);
    bus(STATUS_OFF, 1'b0, 32'h0);
    check("busy", 32'(rd[4]), 32'h0);
    finish_test;
  end
endmodule

// File: bench/tuner_model.sv
`timescale 1ns/10ps
module tuner_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_out,
  input wire logic clk_oe,
  input wire logic dat_out,
  input wire logic dat_oe,
  input wire logic burst_blank,
  output logic [7:0] rx_byte,
  output logic [7:0] n_bits,
  output logic positioning_muted
);
  // ----------------------------------------------------------------
  // Open-drain lines, pulled up when released
  // ----------------------------------------------------------------
  wire logic scl = clk_oe ? clk_out : 1'b1;
  wire logic sda = dat_oe ? dat_out : 1'b1;
  logic scl_q;
  logic [1:0] blank_sync;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      rx_byte <= 8'h00;
      n_bits <= 8'h00;
      blank_sync <= 2'h0;
    end else begin
      scl_q <= scl;
      blank_sync <= {blank_sync[0], burst_blank};
      if (scl && !scl_q) begin
        rx_byte <= {rx_byte[6:0], sda};
        n_bits <= n_bits + 8'h01;
      end
    end
  end

  // Host mutes its positioning receiver while blanking
  assign positioning_muted = blank_sync[1];
endmodule

// File: design/sideband_pkg.sv
package sideband_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] POWER_OFF = 8'h04;
  localparam logic [7:0] BAND_OFF = 8'h08;
  localparam logic [7:0] TUNER_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h10;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tuner_serial;
    logic refclk_on;
    logic radio_sw_on;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = '{tuner_serial: 1'b0, refclk_on: 1'b0, radio_sw_on: 1'b1};

  typedef struct packed {
    logic [7:0] threshold;
    logic [7:0] nominal;
  } power_t;
  localparam logic [7:0] POWER_NOMINAL_RESET = 8'h17;
  localparam logic [7:0] POWER_THRESHOLD_RESET = 8'h10;

  localparam int TUNER_PAR_W = 3;
  localparam int TUNER_SER_W = 8;
  localparam int TUNER_SER_LSB = 8;
  localparam int POWER_W = 8;
  localparam int BAND_W = 8;
  localparam logic [7:0] BLANK_BAND = 8'h27;

  // Strap levels: three grounded, the fourth not connected (reads 1)
  localparam logic [3:0] STRAP_LEVELS = 4'h8;
  localparam int STRAP_STAT_LSB = 8;
  localparam int POWER_STAT_LSB = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TUNER_SCLK_HZ = 1_000_000;
  localparam int TUNER_HALF_CYC = (CLK_HZ / TUNER_SCLK_HZ / 2) < 1 ? 1 :
                                  (CLK_HZ / TUNER_SCLK_HZ / 2);

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// File: design/tuner_serial.sv
`timescale 1ns/10ps
module tuner_serial
  import sideband_pkg::*;
#(
  parameter int WIDTH = TUNER_SER_W,
  parameter int HALF = TUNER_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [WIDTH-1:0] data,
  output logic busy,
  output logic clk_oe,
  output logic dat_oe
);

  typedef enum logic {S_IDLE, S_SHIFT} ser_state_t;

  ser_state_t state;
  logic [WIDTH-1:0] shreg;
  logic [$clog2(WIDTH+1)-1:0] bits_left;
  logic [$clog2(HALF+1)-1:0] tick;
  logic phase_high;
  wire tick_done = (tick == ($clog2(HALF+1))'(HALF - 1));

  // ----------------------------------------------------------------
  // Shift engine, MSB first, data changes while clock is low
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      shreg <= '0;
      bits_left <= '0;
      tick <= '0;
      phase_high <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          tick <= '0;
          phase_high <= 1'b1;
          if (start) begin
            shreg <= data;
            bits_left <= ($clog2(WIDTH+1))'(WIDTH);
            phase_high <= 1'b0;
            state <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          tick <= tick_done ? '0 : tick + 1'b1;
          if (tick_done) begin
            phase_high <= ~phase_high;
            if (phase_high) begin
              shreg <= {shreg[WIDTH-2:0], 1'b0};
              bits_left <= bits_left - 1'b1;
              if (bits_left == ($clog2(WIDTH+1))'(1)) begin
                state <= S_IDLE;
              end
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Open drain: enable pulls low, released line floats high
  assign busy = (state == S_SHIFT);
  assign clk_oe = busy && !phase_high;
  assign dat_oe = busy && !shreg[WIDTH-1];

endmodule

// File: design/wwan_sideband.sv
`timescale 1ns/10ps
module wwan_sideband
  import sideband_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic radio_kill_n,
  input wire logic body_proximity_n,
  input wire logic tx_burst,
  output logic burst_blank,
  output logic radio_enable,
  output logic flight_mode,
  output logic [POWER_W-1:0] tx_power_max,
  output logic refclk_enable,
  output logic [TUNER_PAR_W-1:0] tuner_par,
  output logic tuner_serial_clk_out,
  output logic tuner_serial_clk_oe,
  output logic tuner_serial_dat_out,
  output logic tuner_serial_dat_oe,
  output logic [2:0] config_strap
);

  // ----------------------------------------------------------------
  // Bus slave: address phase capture
  // ----------------------------------------------------------------
  logic dp_write;
  logic [7:0] dp_addr;
  ctrl_t ctrl;
  power_t power;
  logic [BAND_W-1:0] band;
  logic [TUNER_PAR_W-1:0] tuner_par_reg;
  logic [TUNER_SER_W-1:0] tuner_ser_reg;
  logic ser_busy;

  wire ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire ap_write = ap_valid && hwrite;
  wire ap_read = ap_valid && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= '0;
    end else begin
      dp_write <= ap_write;
      dp_addr <= ap_write ? haddr[7:0] : dp_addr;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  wire wr_ctrl = dp_write && hit(dp_addr, CTRL_OFF);
  wire wr_power = dp_write && hit(dp_addr, POWER_OFF);
  wire wr_band = dp_write && hit(dp_addr, BAND_OFF);
  wire wr_tuner = dp_write && hit(dp_addr, TUNER_OFF);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  wire ctrl_t next_ctrl = wr_ctrl ? ctrl_t'(hwdata[$bits(ctrl_t)-1:0]) : ctrl;
  wire power_t next_power = wr_power ? power_t'(hwdata[$bits(power_t)-1:0]) : power;
  wire [BAND_W-1:0] next_band = wr_band ? hwdata[BAND_W-1:0] : band;
  wire [TUNER_PAR_W-1:0] next_tuner_par = wr_tuner ? hwdata[TUNER_PAR_W-1:0] : tuner_par_reg;
  wire ser_take = wr_tuner && ctrl.tuner_serial && !ser_busy;
  wire [TUNER_SER_W-1:0] next_tuner_ser =
    ser_take ? hwdata[TUNER_SER_LSB +: TUNER_SER_W] : tuner_ser_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
      power <= '{threshold: POWER_THRESHOLD_RESET, nominal: POWER_NOMINAL_RESET};
      band <= '0;
      tuner_par_reg <= '0;
      tuner_ser_reg <= '0;
    end else begin
      ctrl <= next_ctrl;
      power <= next_power;
      band <= next_band;
      tuner_par_reg <= next_tuner_par;
      tuner_ser_reg <= next_tuner_ser;
    end
  end

  // ----------------------------------------------------------------
  // Pin-facing logic
  // ----------------------------------------------------------------
  wire next_radio_enable = radio_kill_n && next_ctrl.radio_sw_on;
  wire in_blank_band = (next_band == BLANK_BAND);
  wire next_blank = next_radio_enable && in_blank_band && tx_burst;
  wire prox_near = !body_proximity_n;
  wire [POWER_W-1:0] next_power_max =
    prox_near ? next_power.threshold : next_power.nominal;
  wire [TUNER_PAR_W-1:0] next_par =
    next_ctrl.tuner_serial ? '0 : next_tuner_par;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_blank <= 1'b0;
      radio_enable <= 1'b0;
      flight_mode <= 1'b1;
      tx_power_max <= POWER_NOMINAL_RESET;
      refclk_enable <= 1'b0;
      tuner_par <= '0;
      config_strap <= '0;
    end else begin
      burst_blank <= next_blank;
      radio_enable <= next_radio_enable;
      flight_mode <= !next_radio_enable;
      tx_power_max <= next_power_max;
      refclk_enable <= next_ctrl.refclk_on;
      tuner_par <= next_par;
      config_strap <= STRAP_LEVELS[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Serial tuner, open drain
  // ----------------------------------------------------------------
  logic ser_clk_oe;
  logic ser_dat_oe;

  tuner_serial #(
    .WIDTH(TUNER_SER_W),
    .HALF(TUNER_HALF_CYC)
  ) u_tuner_serial (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(ser_take),
    .data(hwdata[TUNER_SER_LSB +: TUNER_SER_W]),
    .busy(ser_busy),
    .clk_oe(ser_clk_oe),
    .dat_oe(ser_dat_oe)
  );

  assign tuner_serial_clk_out = 1'b0;
  assign tuner_serial_dat_out = 1'b0;
  assign tuner_serial_clk_oe = ctrl.tuner_serial && ser_clk_oe;
  assign tuner_serial_dat_oe = ctrl.tuner_serial && ser_dat_oe;

  // ----------------------------------------------------------------
  // Frame length watch for the serial checks
  // ----------------------------------------------------------------
  localparam int FRAME_CYC = 2 * TUNER_HALF_CYC * TUNER_SER_W;
  localparam int FRAME_CW = $clog2(FRAME_CYC + 2);
  logic [FRAME_CW-1:0] busy_cyc;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_cyc <= '0;
    end else begin
      busy_cyc <= ser_busy ? busy_cyc + 1'b1 : '0;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered at the address phase
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign status_word = {8'h00, next_power_max, 4'h0, STRAP_LEVELS,
                        3'h0, ser_busy, next_blank, prox_near,
                        !next_radio_enable, next_radio_enable};

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      CTRL_OFF: rd_word[$bits(ctrl_t)-1:0] = next_ctrl;
      POWER_OFF: rd_word[$bits(power_t)-1:0] = next_power;
      BAND_OFF: rd_word[BAND_W-1:0] = next_band;
      TUNER_OFF: rd_word = {16'h0000, next_tuner_ser, 5'h00, next_tuner_par};
      STATUS_OFF: rd_word = status_word;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_read) begin
      hrdata <= rd_word;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_blank_off_band;
    @(posedge hclk) disable iff (!hresetn)
      (band != BLANK_BAND) && !wr_band |=> !burst_blank;
  endproperty
  a_blank_off_band: assert property (p_blank_off_band)
    else $error("blanking pulsed outside band 39");

  property p_blank_follows;
    @(posedge hclk) disable iff (!hresetn)
      tx_burst && (next_band == BLANK_BAND) && next_radio_enable |=> burst_blank;
  endproperty
  a_blank_follows: assert property (p_blank_follows)
    else $error("blanking missed a burst");

  property p_kill_low;
    @(posedge hclk) disable iff (!hresetn)
      !radio_kill_n |=> !radio_enable && flight_mode;
  endproperty
  a_kill_low: assert property (p_kill_low)
    else $error("radio stayed on with kill low");

  property p_kill_high;
    @(posedge hclk) disable iff (!hresetn)
      radio_kill_n && next_ctrl.radio_sw_on |=> radio_enable && !flight_mode;
  endproperty
  a_kill_high: assert property (p_kill_high)
    else $error("radio not enabled with kill high");

  property p_sw_off;
    @(posedge hclk) disable iff (!hresetn)
      wr_ctrl && !hwdata[0] |=> !radio_enable && flight_mode && !ctrl.radio_sw_on;
  endproperty
  a_sw_off: assert property (p_sw_off)
    else $error("software radio off ignored");

  property p_prox_near;
    @(posedge hclk) disable iff (!hresetn)
      !body_proximity_n && !wr_power |=> tx_power_max == power.threshold;
  endproperty
  a_prox_near: assert property (p_prox_near)
    else $error("power not capped under proximity");

  property p_prox_far;
    @(posedge hclk) disable iff (!hresetn)
      body_proximity_n && !wr_power |=> tx_power_max == power.nominal;
  endproperty
  a_prox_far: assert property (p_prox_far)
    else $error("power not nominal without proximity");

  property p_refclk_off;
    @(posedge hclk) disable iff (!hresetn)
      !ctrl.refclk_on && !wr_ctrl |=> !refclk_enable;
  endproperty
  a_refclk_off: assert property (p_refclk_off)
    else $error("reference clock on while disabled");

  property p_par_mode;
    @(posedge hclk) disable iff (!hresetn)
      !ctrl.tuner_serial && !wr_ctrl && !wr_tuner
        |=> tuner_par == $past(tuner_par_reg) && !tuner_serial_clk_oe;
  endproperty
  a_par_mode: assert property (p_par_mode)
    else $error("parallel tuner bits wrong");

  property p_open_drain;
    @(posedge hclk) disable iff (!hresetn)
      tuner_serial_clk_oe || tuner_serial_dat_oe
        |-> ctrl.tuner_serial && !tuner_serial_clk_out && !tuner_serial_dat_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("tuner line driven high or outside serial mode");

  property p_ser_quiet;
    @(posedge hclk) disable iff (!hresetn)
      !ser_busy |-> !tuner_serial_clk_oe && !tuner_serial_dat_oe;
  endproperty
  a_ser_quiet: assert property (p_ser_quiet)
    else $error("tuner lines pulled low outside a frame");

  property p_ser_start;
    @(posedge hclk) disable iff (!hresetn)
      ser_take |=> ser_busy;
  endproperty
  a_ser_start: assert property (p_ser_start)
    else $error("serial tuner write did not start a frame");

  property p_ser_len;
    @(posedge hclk) disable iff (!hresetn)
      ser_busy |-> busy_cyc < FRAME_CYC;
  endproperty
  a_ser_len: assert property (p_ser_len)
    else $error("serial tuner frame too long");

  property p_ser_end;
    @(posedge hclk) disable iff (!hresetn)
      !ser_busy && busy_cyc != '0 |-> busy_cyc == FRAME_CYC;
  endproperty
  a_ser_end: assert property (p_ser_end)
    else $error("serial tuner frame ended early");

  property p_par_zero;
    @(posedge hclk) disable iff (!hresetn)
      ctrl.tuner_serial && !wr_ctrl |=> tuner_par == '0;
  endproperty
  a_par_zero: assert property (p_par_zero)
    else $error("parallel tuner bits set in serial mode");

  property p_flight_inv;
    @(posedge hclk) disable iff (!hresetn)
      flight_mode == !radio_enable;
  endproperty
  a_flight_inv: assert property (p_flight_inv)
    else $error("flight mode not inverse of radio enable");

  property p_power_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_power |=> power == $past(hwdata[$bits(power_t)-1:0]);
  endproperty
  a_power_write: assert property (p_power_write)
    else $error("power threshold write lost");

  property p_bus_okay;
    @(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("register bus stalled or errored");

  property p_strap_ground;
    @(posedge hclk) disable iff (!hresetn)
      config_strap == '0;
  endproperty
  a_strap_ground: assert property (p_strap_ground)
    else $error("type strap not grounded");

endmodule
